// File: rtl/card_status_pkg.sv
// Constants shared by the card host status flag block.
package card_status_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_SEC    = 8'h04;
  localparam logic [7:0] OFS_MASK   = 8'h08;
  localparam logic [7:0] OFS_CTL    = 8'h0C;
  localparam logic [7:0] OFS_CMD    = 8'h10;
  localparam logic [7:0] OFS_TXD    = 8'h14;
  localparam logic [7:0] OFS_RXD    = 8'h18;
  // Primary status bit positions.
  localparam int BIT_DATA_DONE = 0;
  localparam int BIT_BUSY_DONE = 1;
  localparam int BIT_RESP_DONE = 2;
  localparam int BIT_RD_TOUT   = 3;
  localparam int BIT_RESP_TOUT = 4;
  localparam int BIT_WR_CRC    = 5;
  localparam int BIT_RD_CRC    = 6;
  localparam int BIT_RESP_CRC  = 7;
  localparam int BIT_TX_READY  = 9;
  localparam int BIT_RX_READY  = 10;
  localparam int BIT_XFER_DONE = 12;
  // Control and command field positions.
  localparam int CTL_DLR_BIT  = 0;
  localparam int CMD_DATA_PATH_CLEAR_BIT = 16;
  // Implemented status bits, bits cleared by a read, reset value.
  localparam logic [31:0] STAT_BITS   = 32'h0000_16FF;
  localparam logic [31:0] RDCLR_BITS  = 32'h0000_10FF;
  localparam logic [31:0] STAT_RESET  = 32'h0000_0200;
  localparam int          SEC_W       = 7;
endpackage : card_status_pkg

// File: rtl/card_host_status_flags.sv
// Primary and secondary status flags with a Wishbone register slave and interrupt.
//
// Register access over Wishbone and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module card_host_status_flags
  import card_status_pkg::*;
(
  input  wire logic             sys_clk,          // 40 MHz clock.
  input  wire logic             rst_n,            // Asynchronous reset, active low.
  input  wire logic             wb_cyc_i,         // Bus cycle.
  input  wire logic             wb_stb_i,         // Bus strobe.
  input  wire logic             wb_we_i,          // Write enable.
  input  wire logic [7:0]       wb_adr_i,         // Byte address.
  input  wire logic [3:0]       wb_sel_i,         // Byte enables.
  input  wire logic [31:0]      wb_dat_i,         // Write data.
  output logic      [31:0]      wb_dat_o,         // Read data.
  output logic                  wb_ack_o,         // Acknowledge.
  input  wire logic             resp_crc_err,     // Response CRC error pulse.
  input  wire logic             rd_crc_err,       // Read-data CRC error pulse.
  input  wire logic             wr_crc_err,       // Write-data CRC error pulse.
  input  wire logic             resp_timeout,     // Response timeout pulse.
  input  wire logic             rd_timeout,       // Read-data timeout pulse.
  input  wire logic             resp_done,        // Response or no-response command done.
  input  wire logic             busy_release,     // Card released busy.
  input  wire logic             busy_missing,     // Expected busy not seen.
  input  wire logic             xfer_last_byte,   // Last byte of transfer done.
  input  wire logic             data_complete,    // CRC check and programming done.
  input  wire logic             tx_word_taken,    // Data path took the transmit word.
  input  wire logic             rx_word_valid,    // New receive word arrived.
  input  wire logic [31:0]      rx_word,          // Receive word.
  input  wire logic [SEC_W-1:0] sec_status_in,    // Secondary status levels.
  output logic      [31:0]      tx_data_reg,      // Transmit word.
  output logic                  tx_write_pulse,   // Transmit word written.
  output logic      [31:0]      command_reg,      // Command word.
  output logic                  cmd_issue_pulse,  // Command issued.
  output logic                  data_logic_reset, // Data logic reset level.
  output logic                  irq               // Interrupt, active high level.
);

  // All state of the block.
  typedef struct packed {
    logic [31:0]      stat;
    logic [31:0]      mask;
    logic [SEC_W-1:0] sec;
    logic             dlr;
    logic             xfer_seen;
    logic [31:0]      txd;
    logic             tx_wr;
    logic [31:0]      cmd;
    logic             cmd_iss;
    logic             ack;
    logic [31:0]      dat;
    logic             irq;
  } state_type;

  state_type   s_r;
  state_type   s_nxt;
  logic        req;
  logic [31:0] wmask;
  logic [31:0] ev;
  logic [31:0] clr;
  logic        data_path_clear;
  logic        tx_wr_now;
  logic        rx_read;

  // Next-state logic for the bus slave, the flags and the interrupt.
  always_comb begin
    s_nxt = s_r;
    s_nxt.ack = 1'b0;
    s_nxt.tx_wr = 1'b0;
    s_nxt.cmd_iss = 1'b0;
    s_nxt.sec = sec_status_in;
    req = wb_cyc_i & wb_stb_i & ~s_r.ack;
    wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    clr = 32'h0000_0000;
    data_path_clear = 1'b0;
    tx_wr_now = 1'b0;
    rx_read = 1'b0;
    // Decode one access; side effects happen in the cycle the access is taken.
    if (req) begin
      s_nxt.ack = 1'b1;
      s_nxt.dat = 32'h0000_0000;
      if (wb_we_i) begin
        case (wb_adr_i)
          OFS_STATUS: clr = wb_dat_i & wmask & RDCLR_BITS;
          OFS_MASK:   s_nxt.mask = (s_r.mask & ~wmask) | (wb_dat_i & wmask & STAT_BITS);
          OFS_CTL: begin
            if (wb_sel_i[0]) begin
              s_nxt.dlr = wb_dat_i[CTL_DLR_BIT];
            end
          end
          OFS_CMD: begin
            if (&wb_sel_i) begin
              s_nxt.cmd = wb_dat_i;
              s_nxt.cmd_iss = 1'b1;
              data_path_clear = wb_dat_i[CMD_DATA_PATH_CLEAR_BIT];
            end
          end
          OFS_TXD: begin
            if (&wb_sel_i) begin
              s_nxt.txd = wb_dat_i;
              s_nxt.tx_wr = 1'b1;
              tx_wr_now = 1'b1;
            end
          end
          default: ;
        endcase
      end else begin
        case (wb_adr_i)
          OFS_STATUS: begin
            s_nxt.dat = s_r.stat;
            clr = RDCLR_BITS;
          end
          OFS_SEC:  s_nxt.dat = {{(32-SEC_W){1'b0}}, s_r.sec};
          OFS_MASK: s_nxt.dat = s_r.mask;
          OFS_CTL:  s_nxt.dat = {31'h0000_0000, s_r.dlr};
          OFS_CMD:  s_nxt.dat = s_r.cmd;
          OFS_TXD:  s_nxt.dat = s_r.txd;
          OFS_RXD: begin
            s_nxt.dat = rx_word;
            rx_read = 1'b1;
          end
          default: s_nxt.dat = 32'h0000_0000;
        endcase
      end
    end
    // Collect the event pulses from the command and data path.
    ev = 32'h0000_0000;
    ev[BIT_RESP_CRC] = resp_crc_err;
    ev[BIT_RD_CRC] = rd_crc_err;
    ev[BIT_WR_CRC] = wr_crc_err;
    ev[BIT_RESP_TOUT] = resp_timeout;
    ev[BIT_RD_TOUT] = rd_timeout;
    ev[BIT_RESP_DONE] = resp_done;
    ev[BIT_BUSY_DONE] = busy_release | busy_missing;
    ev[BIT_XFER_DONE] = xfer_last_byte;
    // Data done waits until the last byte has been seen as well.
    ev[BIT_DATA_DONE] = data_complete & (s_r.xfer_seen | xfer_last_byte);
    if (ev[BIT_DATA_DONE] | s_r.dlr) begin
      s_nxt.xfer_seen = 1'b0;
    end else if (xfer_last_byte) begin
      s_nxt.xfer_seen = 1'b1;
    end
    // Sticky bits: an event in the clearing cycle still sets its bit.
    s_nxt.stat = ((s_r.stat & ~clr) | ev) & STAT_BITS;
    // Transmit-ready follows its functional events only.
    if (s_r.dlr | data_path_clear | tx_wr_now) begin
      s_nxt.stat[BIT_TX_READY] = 1'b1;
    end else if (tx_word_taken) begin
      s_nxt.stat[BIT_TX_READY] = 1'b0;
    end else begin
      s_nxt.stat[BIT_TX_READY] = s_r.stat[BIT_TX_READY];
    end
    // Receive-ready: a new word wins over a read, the data logic reset wins over all.
    if (s_r.dlr) begin
      s_nxt.stat[BIT_RX_READY] = 1'b0;
    end else if (rx_word_valid) begin
      s_nxt.stat[BIT_RX_READY] = 1'b1;
    end else if (data_path_clear | rx_read) begin
      s_nxt.stat[BIT_RX_READY] = 1'b0;
    end else begin
      s_nxt.stat[BIT_RX_READY] = s_r.stat[BIT_RX_READY];
    end
    // Interrupt from unmasked primary bits only; secondary bits take no part.
    s_nxt.irq = |(s_nxt.stat & s_nxt.mask);
  end

  // State register.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.stat <= STAT_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs come straight from the state flip-flops.
  assign wb_dat_o = s_r.dat;
  assign wb_ack_o = s_r.ack;
  assign tx_data_reg = s_r.txd;
  assign tx_write_pulse = s_r.tx_wr;
  assign command_reg = s_r.cmd;
  assign cmd_issue_pulse = s_r.cmd_iss;
  assign data_logic_reset = s_r.dlr;
  assign irq = s_r.irq;

  // A held data logic reset keeps transmit-ready high.
  a_txrdy_on_dlr: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_r.dlr |=> s_r.stat[BIT_TX_READY])
    else $error("transmit ready not set by data logic reset");

  // A transmit word write sets transmit-ready unless it is taken at once.
  a_txrdy_on_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_r.tx_wr ##0 !tx_word_taken |-> ##0 s_r.stat[BIT_TX_READY] ##1 s_r.stat[BIT_TX_READY])
    else $error("transmit ready lost after a write");

  // A taken word clears transmit-ready when no set source is active.
  a_txrdy_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tx_word_taken && !s_r.dlr && !(req && wb_we_i) |=> !s_r.stat[BIT_TX_READY])
    else $error("transmit ready not cleared when word taken");

  // Each CRC error pulse is seen in the status one cycle later.
  a_crc_flags_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    resp_crc_err || rd_crc_err || wr_crc_err
    |=> (s_r.stat[BIT_RESP_CRC] || !$past(resp_crc_err))
        && (s_r.stat[BIT_RD_CRC] || !$past(rd_crc_err))
        && (s_r.stat[BIT_WR_CRC] || !$past(wr_crc_err)))
    else $error("CRC error flag not set");

  // Timeouts and response done set their bits even during a clearing read.
  a_resp_tout_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    resp_timeout |=> s_r.stat[BIT_RESP_TOUT])
    else $error("response timeout flag not set");

  a_rd_tout_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_timeout |=> s_r.stat[BIT_RD_TOUT])
    else $error("read timeout flag not set");

  a_resp_done_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    resp_done |=> s_r.stat[BIT_RESP_DONE])
    else $error("response done flag not set");

  a_busy_done_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    busy_release || busy_missing |=> s_r.stat[BIT_BUSY_DONE])
    else $error("busy done flag not set");

  // Data done never rises without a last byte since the previous data done.
  a_data_done_order: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(s_r.stat[BIT_DATA_DONE]) |-> $past(s_r.xfer_seen) || $past(xfer_last_byte))
    else $error("data done before transfer done");

  // A quiet status read returns the bits and leaves only the ready flags.
  a_read_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
    req && !wb_we_i && wb_adr_i == OFS_STATUS && ev == 32'h0000_0000
    |=> wb_ack_o && wb_dat_o == $past(s_r.stat) && (s_r.stat & RDCLR_BITS) == 32'h0000_0000)
    else $error("status read did not clear");

  // An unmasked event drives the interrupt high in the next cycle.
  a_irq_raise: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ev & s_r.mask) != 32'h0000_0000 && !(req && wb_we_i) |=> irq)
    else $error("interrupt not raised");

  // Secondary status changes never raise the interrupt by themselves.
  a_sec_no_irq: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !irq && ev == 32'h0000_0000 && !rx_word_valid && !tx_word_taken && !req && !s_r.dlr
    && $changed(sec_status_in) |=> !irq)
    else $error("secondary status raised interrupt");

  // Every access is acknowledged in exactly the next cycle, for one cycle.
  a_wb_ack_timing: assert property (@(posedge sys_clk) disable iff (!rst_n)
    req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus acknowledge timing wrong");

  // A response CRC flag only rises after its own error pulse.
  a_resp_crc_cause: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(s_r.stat[BIT_RESP_CRC]) |-> $past(resp_crc_err))
    else $error("response CRC flag set without error");

  // A read-data CRC flag only rises after its own error pulse.
  a_rd_crc_cause: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(s_r.stat[BIT_RD_CRC]) |-> $past(rd_crc_err))
    else $error("read CRC flag set without error");

  // A write-data CRC flag only rises after its own error pulse.
  a_wr_crc_cause: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(s_r.stat[BIT_WR_CRC]) |-> $past(wr_crc_err))
    else $error("write CRC flag set without error");

  // Busy done only rises after a busy release or a missing busy.
  a_busy_done_cause: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(s_r.stat[BIT_BUSY_DONE]) |-> $past(busy_release) || $past(busy_missing))
    else $error("busy done flag set without cause");

  // Completion after a seen last byte sets data done.
  a_data_done_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    data_complete && (s_r.xfer_seen || xfer_last_byte) |=> s_r.stat[BIT_DATA_DONE])
    else $error("data done flag not set");

  // The last byte of a transfer sets transfer done.
  a_xfer_done_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    xfer_last_byte |=> s_r.stat[BIT_XFER_DONE])
    else $error("transfer done flag not set");

  // A command with the data path clear option sets transmit-ready.
  a_txrdy_on_data_path_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    req && wb_we_i && wb_adr_i == OFS_CMD && wb_sel_i == 4'hF && wb_dat_i[CMD_DATA_PATH_CLEAR_BIT]
    |=> s_r.stat[BIT_TX_READY])
    else $error("transmit ready not set by data path clear");

  // A status read leaves both ready flags alone when no functional event occurs.
  a_ready_kept_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
    req && !wb_we_i && wb_adr_i == OFS_STATUS && !s_r.dlr
    && !tx_word_taken && !rx_word_valid
    |=> s_r.stat[BIT_TX_READY] == $past(s_r.stat[BIT_TX_READY])
        && s_r.stat[BIT_RX_READY] == $past(s_r.stat[BIT_RX_READY]))
    else $error("ready flag changed by status read");

  // Writing ones to the status clears those event bits when no event arrives.
  a_w1c_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
    req && wb_we_i && wb_adr_i == OFS_STATUS && wb_sel_i == 4'hF && ev == 32'h0000_0000
    |=> (s_r.stat & $past(wb_dat_i) & RDCLR_BITS) == 32'h0000_0000)
    else $error("status write did not clear");

  // A rising unmasked ready flag raises the interrupt in the same cycle.
  a_irq_on_ready: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ($rose(s_r.stat[BIT_TX_READY]) && s_r.mask[BIT_TX_READY])
    || ($rose(s_r.stat[BIT_RX_READY]) && s_r.mask[BIT_RX_READY]) |-> irq)
    else $error("interrupt not raised by ready flag");

endmodule : card_host_status_flags

// File: tb/card_host_status_flags_tb.sv
// Self-checking bench for the card host status flag block.
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module card_host_status_flags_tb;
  import card_status_pkg::*;
  logic             sys_clk, rst_n, cyc, stb, we, irq, ack, dlr, txp, cip;
  logic [7:0]       adr;
  logic [3:0]       sel;
  logic [11:0]      ev;
  logic [31:0]      wdat, rdat, txd, cmd, rxw, stat_m, mask_m, d, txw, cmw;
  logic [SEC_W-1:0] sec;
  int               fail_count, total_checks;
  bit               seen;
  // Status bit touched by each event input, in ev order.
  int ebit [12] = '{7, 6, 5, 4, 3, 2, 1, 1, 12, 0, 9, 10};

  card_host_status_flags card_host_status_flags_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .resp_crc_err(ev[0]), .rd_crc_err(ev[1]), .wr_crc_err(ev[2]), .resp_timeout(ev[3]),
    .rd_timeout(ev[4]), .resp_done(ev[5]), .busy_release(ev[6]), .busy_missing(ev[7]),
    .xfer_last_byte(ev[8]), .data_complete(ev[9]), .tx_word_taken(ev[10]),
    .rx_word_valid(ev[11]), .rx_word(rxw), .sec_status_in(sec), .tx_data_reg(txd),
    .tx_write_pulse(txp), .command_reg(cmd), .cmd_issue_pulse(cip), .data_logic_reset(dlr),
    .irq(irq));

  // Clock at 40 MHz.
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Prints the verdict and stops the run.
  task automatic end_of_test;
    if (fail_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  // One classic bus cycle; a read compares the word with e, then the model follows.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dd,
                    input logic [3:0] s, input logic [31:0] e);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= dd;
    sel <= s;
    do begin
      @(posedge sys_clk);
    end while (ack !== 1'b1);
    if (!w) `CHK(rdat, e)
    `CHK(txp, w && a == OFS_TXD && s == 4'hF)
    `CHK(cip, w && a == OFS_CMD && s == 4'hF)
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (w && a == OFS_STATUS) stat_m &= ~(dd & RDCLR_BITS);
    if (w && a == OFS_MASK) mask_m = dd & STAT_BITS;
    if (w && s == 4'hF && a == OFS_TXD) txw = dd;
    if (w && s == 4'hF && a == OFS_CMD) cmw = dd;
    if (w && s == 4'hF && (a == OFS_TXD || (a == OFS_CMD && dd[16]))) stat_m[9] = 1'b1;
    if (w && a == OFS_CMD && s == 4'hF && dd[16]) stat_m[10] = 1'b0;
    if (w && a == OFS_CTL && s[0] && dd[0]) begin
      stat_m[9] = 1'b1;
      stat_m[10] = 1'b0;
      seen = 1'b0;
    end
    if (!w && a == OFS_STATUS) stat_m &= ~RDCLR_BITS;
    if (!w && a == OFS_RXD) stat_m[10] = 1'b0;
    @(posedge sys_clk);
  endtask : wb

  // One-cycle event pulse on input i, with the model's reaction.
  task automatic pulse(input int i);
    ev <= 12'(1 << i);
    @(posedge sys_clk);
    ev <= '0;
    @(posedge sys_clk);
    if (i == 8) seen = 1'b1;
    if (i == 10) stat_m[9] = 1'b0;
    else if (i != 9 || seen) stat_m[ebit[i]] = 1'b1;
    if (i == 9) seen = 1'b0;
  endtask : pulse

  // Watchdog cuts a hung run short.
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    end_of_test();
  end

  // Main sequence.
  initial begin
    {cyc, stb, we, adr, sel, wdat, ev} = '0;
    rst_n = 1'b0;
    void'($urandom(94705));
    rxw = $urandom;
    sec = '0;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    stat_m = STAT_RESET;
    mask_m = '0;
    seen = 1'b0;
    wb(0, OFS_STATUS, 0, 4'hF, stat_m);
    wb(1, OFS_MASK, STAT_BITS, 4'hF, 0);
    // Every event input in turn, then a second read that must show the cleared flags.
    for (int i = 0; i < 12; i++) begin
      pulse(i);
      `CHK(irq, |(stat_m & mask_m))
      wb(0, OFS_STATUS, 0, 4'hF, stat_m);
      wb(0, OFS_STATUS, 0, 4'hF, stat_m);
    end
    wb(0, OFS_RXD, 0, 4'hF, rxw);
    // Data completion without a last byte must not flag data done.
    pulse(9);
    wb(0, OFS_STATUS, 0, 4'hF, stat_m);
    // Each way of making the transmit register ready, and a refused partial write.
    for (int k = 0; k < 4; k++) begin
      d = $urandom;
      pulse(10);
      case (k)
        0: wb(1, OFS_TXD, d, 4'hF, 0);
        1: wb(1, OFS_CMD, {d[31:17], 1'b1, d[15:0]}, 4'hF, 0);
        2: wb(1, OFS_CTL, 32'h0000_0001, 4'hF, 0);
        default: wb(1, OFS_TXD, d, 4'h7, 0);
      endcase
      if (k == 0) `CHK(txd, d)
      if (k == 1) `CHK(cmd, {d[31:17], 1'b1, d[15:0]})
      if (k == 2) `CHK(dlr, 1'b1)
      if (k == 2) wb(1, OFS_CTL, 0, 4'hF, 0);
      wb(0, OFS_STATUS, 0, 4'hF, stat_m);
    end
    wb(0, OFS_TXD, 0, 4'hF, txw);
    wb(0, OFS_CMD, 0, 4'hF, cmw);
    wb(0, OFS_CTL, 0, 4'hF, 32'h0000_0000);
    // Masked and unmasked events, and write-one-to-clear.
    wb(1, OFS_MASK, 32'h0000_0080, 4'hF, 0);
    wb(0, OFS_MASK, 0, 4'hF, mask_m);
    pulse(0);
    `CHK(irq, 1'b1)
    wb(1, OFS_STATUS, 32'h0000_0080, 4'hF, 0);
    `CHK(irq, 1'b0)
    pulse(1);
    `CHK(irq, 1'b0)
    wb(0, OFS_STATUS, 0, 4'hF, stat_m);
    // Secondary levels are readable but never interrupt.
    wb(1, OFS_MASK, STAT_BITS, 4'hF, 0);
    pulse(10);
    for (int k = 0; k < 4; k++) begin
      d = $urandom;
      sec <= d[SEC_W-1:0];
      repeat (2) @(posedge sys_clk);
      wb(0, OFS_SEC, 0, 4'hF, {25'h0, d[SEC_W-1:0]});
      `CHK(irq, 1'b0)
    end
    wb(0, 8'h1C, 0, 4'hF, 32'h0000_0000);
    end_of_test();
  end
endmodule : card_host_status_flags_tb
